// [logic/csl_pkg.sv]
package csl_pkg;

    // Stored set selector codes.
    typedef enum logic [1:0] {
        CSL_SET_USER1,
        CSL_SET_USER2,
        CSL_SET_USER3,
        CSL_SET_DEFAULT
    } csl_set_t;

    localparam int CSL_PARAM_W = 16;
    localparam int CSL_PARAM_N = 8;
    localparam int CSL_IDX_W = 3;
    localparam int CSL_PIX_W = 8;
    localparam int CSL_FCNT_W = 32;
    localparam int CSL_STAMP_W = 32;

    // Description file choice encoding; the factory value is basic.
    localparam logic CSL_DESC_BASIC = 1'b0;
    localparam logic CSL_DESC_FULL = 1'b1;
    localparam logic CSL_DESC_RESET = CSL_DESC_BASIC;
    localparam logic [1:0] CSL_STARTUP_RESET = 2'h3;

    // Description processing times after a restart.
    localparam int CSL_CLK_MHZ = 20;
    localparam int CSL_BASIC_PROC_US = 100;
    localparam int CSL_FULL_PROC_US = 200;
    localparam int CSL_BASIC_PROC_CYC = CSL_BASIC_PROC_US * CSL_CLK_MHZ;
    localparam int CSL_FULL_PROC_CYC = CSL_FULL_PROC_US * CSL_CLK_MHZ;
    localparam int CSL_PROC_W = 13;

    // Generated test pattern: value step, per pixel.
    localparam logic [7:0] CSL_TEST_STEP = 8'h01;

endpackage : csl_pkg

// [logic/csl_config_set_loader.sv]
`timescale 1ns/1ns
`default_nettype none
module csl_config_set_loader
    import csl_pkg::*;
#(
    parameter int PARAM_N = CSL_PARAM_N,
    parameter int BASIC_PROC_CYC = CSL_BASIC_PROC_CYC,
    parameter int FULL_PROC_CYC = CSL_FULL_PROC_CYC
) (
    input wire logic sys_clk_i, // 20 MHz clock
    input wire logic resetn_i, // Asynchronous reset, active low
    input wire logic [1:0] stored_set_choice_i, // Set chosen for a load
    input wire logic stored_set_load_cmd_i, // One-cycle load request
    input wire logic [1:0] startup_set_choice_i, // Set loaded after reset
    input wire logic description_file_choice_i, // Persistent description choice
    input wire logic acquiring_i, // Acquisition in progress
    input wire logic nv_read_done_i, // Stored word read finished
    input wire logic [CSL_PARAM_W-1:0] nv_rdata_i, // Stored word data
    input wire logic trailer_mode_on_i, // Trailer mode active
    input wire logic frame_number_en_i, // Frame number trailer enable
    input wire logic test_pattern_en_i, // Test image enable
    input wire logic frame_start_i, // One-cycle pulse per acquired image
    input wire logic frame_end_i, // One-cycle pulse at end of image data
    input wire logic pix_valid_i, // Sensor pixel valid
    input wire logic [CSL_PIX_W-1:0] pix_i, // Sensor pixel
    output logic nv_read_o, // Stored word read request
    output logic [1:0] nv_set_o, // Set being read
    output logic [CSL_IDX_W-1:0] nv_index_o, // Word being read
    output logic [CSL_PARAM_W*PARAM_N-1:0] active_params_o, // Active parameter set
    output logic load_busy_o, // Load in progress
    output logic load_done_o, // Load finished pulse
    output logic load_reject_o, // Load rejected pulse
    output logic description_store_o, // Description choice to persist
    output logic features_ready_o, // Description processed
    output logic colour_adjust_avail_o, // Colour adjustment exposed
    output logic sequencer_avail_o, // Sequencer exposed
    output logic pix_valid_o, // Output pixel valid
    output logic [CSL_PIX_W-1:0] pix_o, // Output pixel
    output logic trailer_valid_o, // Trailer word valid pulse
    output logic [CSL_STAMP_W-1:0] trailer_data_o // Trailer frame stamp
);

    typedef enum logic [1:0] {
        CSL_ST_IDLE,
        CSL_ST_REQ,
        CSL_ST_WAIT
    } csl_state_t;

    csl_state_t state_reg, state_next;
    logic [1:0] set_reg, set_next;
    logic [CSL_IDX_W-1:0] idx_reg, idx_next;
    logic [CSL_PARAM_W-1:0] params_reg [PARAM_N];
    logic [CSL_PARAM_W-1:0] params_next [PARAM_N];
    logic boot_reg, boot_next;
    logic done_reg, done_next;
    logic reject_reg, reject_next;
    logic desc_reg, desc_next;
    logic strap_reg, strap_next;
    logic [CSL_PROC_W-1:0] proc_reg, proc_next;
    logic ready_reg, ready_next;
    logic [CSL_FCNT_W-1:0] fcnt_reg, fcnt_next;
    logic [CSL_STAMP_W-1:0] stamp_reg, stamp_next;
    logic stamp_pend_reg, stamp_pend_next;
    logic tvalid_reg, tvalid_next;
    logic [CSL_STAMP_W-1:0] tdata_reg, tdata_next;
    logic pvalid_reg, pvalid_next;
    logic [CSL_PIX_W-1:0] pix_reg, pix_next;
    logic [CSL_PIX_W-1:0] tp_reg, tp_next;

    // Loader: reset start from the startup choice, then host loads.
    always_comb begin
        state_next = state_reg;
        set_next = set_reg;
        idx_next = idx_reg;
        boot_next = boot_reg;
        done_next = 1'b0;
        reject_next = 1'b0;
        for (int i = 0; i < PARAM_N; i++) begin
            params_next[i] = params_reg[i];
        end
        case (state_reg)
            CSL_ST_IDLE: begin
                if (boot_reg) begin
                    set_next = startup_set_choice_i;
                    idx_next = '0;
                    boot_next = 1'b0;
                    state_next = CSL_ST_REQ;
                end else if (stored_set_load_cmd_i) begin
                    if (acquiring_i) begin
                        reject_next = 1'b1;
                    end else begin
                        set_next = stored_set_choice_i;
                        idx_next = '0;
                        state_next = CSL_ST_REQ;
                    end
                end
            end
            CSL_ST_REQ: begin
                state_next = CSL_ST_WAIT;
            end
            CSL_ST_WAIT: begin
                if (nv_read_done_i) begin
                    params_next[idx_reg] = nv_rdata_i;
                    if (idx_reg == CSL_IDX_W'(PARAM_N - 1)) begin
                        done_next = 1'b1;
                        state_next = CSL_ST_IDLE;
                    end else begin
                        idx_next = idx_reg + 1'b1;
                        state_next = CSL_ST_REQ;
                    end
                end
            end
            default: begin
                state_next = CSL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= CSL_ST_IDLE;
            set_reg <= CSL_STARTUP_RESET;
            idx_reg <= '0;
            boot_reg <= 1'b1;
            done_reg <= 1'b0;
            reject_reg <= 1'b0;
            for (int i = 0; i < PARAM_N; i++) begin
                params_reg[i] <= '0;
            end
        end else begin
            state_reg <= state_next;
            set_reg <= set_next;
            idx_reg <= idx_next;
            boot_reg <= boot_next;
            done_reg <= done_next;
            reject_reg <= reject_next;
            for (int i = 0; i < PARAM_N; i++) begin
                params_reg[i] <= params_next[i];
            end
        end
    end

    // Description choice: the running choice is captured once after reset.
    always_comb begin
        strap_next = 1'b0;
        desc_next = desc_reg;
        proc_next = proc_reg;
        ready_next = ready_reg;
        if (strap_reg) begin
            desc_next = description_file_choice_i;
            proc_next = (description_file_choice_i == CSL_DESC_FULL) ?
                CSL_PROC_W'(FULL_PROC_CYC) : CSL_PROC_W'(BASIC_PROC_CYC);
        end else if (!ready_reg) begin
            if (proc_reg <= CSL_PROC_W'(1)) begin
                ready_next = 1'b1;
            end else begin
                proc_next = proc_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap_reg <= 1'b1;
            desc_reg <= CSL_DESC_RESET;
            proc_reg <= CSL_PROC_W'(FULL_PROC_CYC);
            ready_reg <= 1'b0;
        end else begin
            strap_reg <= strap_next;
            desc_reg <= desc_next;
            proc_reg <= proc_next;
            ready_reg <= ready_next;
        end
    end

    // Pixel path and trailer stamping.
    always_comb begin
        fcnt_next = fcnt_reg;
        stamp_next = stamp_reg;
        stamp_pend_next = stamp_pend_reg;
        tvalid_next = 1'b0;
        tdata_next = tdata_reg;
        pvalid_next = pix_valid_i;
        pix_next = pix_reg;
        tp_next = tp_reg;
        // A trailer that ends in the cycle a new frame starts must not drop the new frame's pending stamp.
        if (trailer_mode_on_i && frame_end_i && stamp_pend_reg && frame_number_en_i) begin
            tvalid_next = 1'b1;
            tdata_next = stamp_reg;
            stamp_pend_next = 1'b0;
        end
        if (frame_start_i) begin
            stamp_next = fcnt_reg;
            fcnt_next = fcnt_reg + 1'b1;
            stamp_pend_next = trailer_mode_on_i && frame_number_en_i;
            tp_next = '0;
        end
        if (pix_valid_i) begin
            if (test_pattern_en_i) begin
                pix_next = tp_reg;
                tp_next = tp_reg + CSL_TEST_STEP;
            end else begin
                pix_next = pix_i;
            end
        end
        if (!trailer_mode_on_i) begin
            stamp_pend_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fcnt_reg <= '0;
            stamp_reg <= '0;
            stamp_pend_reg <= 1'b0;
            tvalid_reg <= 1'b0;
            tdata_reg <= '0;
            pvalid_reg <= 1'b0;
            pix_reg <= '0;
            tp_reg <= '0;
        end else begin
            fcnt_reg <= fcnt_next;
            stamp_reg <= stamp_next;
            stamp_pend_reg <= stamp_pend_next;
            tvalid_reg <= tvalid_next;
            tdata_reg <= tdata_next;
            pvalid_reg <= pvalid_next;
            pix_reg <= pix_next;
            tp_reg <= tp_next;
        end
    end

    generate
        for (genvar g = 0; g < PARAM_N; g++) begin : g_pack
            assign active_params_o[g*CSL_PARAM_W +: CSL_PARAM_W] = params_reg[g];
        end
    endgenerate

    // Features hidden by the basic description appear only once processing is over.
    function automatic logic full_features(input logic ready, input logic desc);
        return ready && (desc == CSL_DESC_FULL);
    endfunction : full_features

    assign nv_read_o = (state_reg == CSL_ST_REQ);
    assign nv_set_o = set_reg;
    assign nv_index_o = idx_reg;
    assign load_busy_o = (state_reg != CSL_ST_IDLE) || boot_reg;
    assign load_done_o = done_reg;
    assign load_reject_o = reject_reg;
    assign description_store_o = description_file_choice_i;
    assign features_ready_o = ready_reg;
    assign colour_adjust_avail_o = full_features(ready_reg, desc_reg);
    assign sequencer_avail_o = full_features(ready_reg, desc_reg);
    assign pix_valid_o = pvalid_reg;
    assign pix_o = pix_reg;
    assign trailer_valid_o = tvalid_reg;
    assign trailer_data_o = tdata_reg;

    AST_REJECT_WHILE_ACQ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == CSL_ST_IDLE && !boot_reg && stored_set_load_cmd_i && acquiring_i) |=> load_reject_o
        && $stable(active_params_o)) else $error("load during acquisition not rejected");

    AST_LOAD_STARTS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == CSL_ST_IDLE && !boot_reg && stored_set_load_cmd_i && !acquiring_i)
        |=> nv_read_o && nv_index_o == '0) else $error("idle load did not start");

    AST_BOOT_LOAD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        boot_reg |=> nv_read_o && nv_set_o == $past(startup_set_choice_i)) else $error("startup load missing");

    AST_WORD_COPY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state_reg == CSL_ST_WAIT && nv_read_done_i)
        |=> params_reg[$past(idx_reg)] == $past(nv_rdata_i)) else $error("stored word not copied");

    AST_BASIC_AVAIL: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (desc_reg == CSL_DESC_BASIC) |-> !colour_adjust_avail_o && !sequencer_avail_o)
        else $error("basic description exposes hidden features");

    AST_PROC_TIME: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(ready_reg) |-> proc_reg <= CSL_PROC_W'(1)) else $error("features ready too early");

    AST_TRAILER_OFF: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !trailer_mode_on_i |=> !stamp_pend_reg && !trailer_valid_o) else $error("trailer left on");

    AST_STAMP_VALUE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        frame_start_i |=> stamp_reg == $past(fcnt_reg) && fcnt_reg == $past(fcnt_reg) + 1)
        else $error("frame stamp wrong");

    AST_TEST_PIX: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (pix_valid_i && test_pattern_en_i) |=> pix_o == $past(tp_reg)) else $error("test pixel not generated");

endmodule : csl_config_set_loader
`default_nettype wire

// [bench/csl_nv_model.sv]
`timescale 1ns/1ns
`default_nettype none
module csl_nv_model
    import csl_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic resetn_i, // Asynchronous reset, active low
    input wire logic slow_i, // Answer after three wait cycles
    input wire logic nv_read_i, // Word read request
    input wire logic [1:0] nv_set_i, // Set being read
    input wire logic [CSL_IDX_W-1:0] nv_index_i, // Word being read
    output logic nv_read_done_o, // Word ready pulse
    output logic [CSL_PARAM_W-1:0] nv_rdata_o // Word data
);
    logic busy;
    logic [1:0] wait_cnt;
    logic [CSL_PARAM_W-1:0] word;
    // Outside an answer the data lines flip, so a stale word is never taken as good.
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy <= 1'b0;
            wait_cnt <= 2'h0;
            word <= 16'h0000;
            nv_read_done_o <= 1'b0;
            nv_rdata_o <= 16'hA5C3;
        end else begin
            nv_read_done_o <= 1'b0;
            nv_rdata_o <= ~nv_rdata_o;
            if (nv_read_i) begin
                busy <= 1'b1;
                wait_cnt <= slow_i ? 2'h3 : 2'h0;
                word <= {nv_set_i, 3'h5, nv_index_i, 8'h96};
            end else if (busy && wait_cnt == 2'h0) begin
                busy <= 1'b0;
                nv_read_done_o <= 1'b1;
                nv_rdata_o <= word;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 2'h1;
            end
        end
    end
endmodule : csl_nv_model
`default_nettype wire

// [bench/csl_config_set_loader_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module csl_config_set_loader_bench;
    import csl_pkg::*;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, slow, nv_read_o, nv_read_done_i, acquiring_i = 1'b0;
    logic [1:0] stored_set_choice_i = 2'h0, startup_set_choice_i = 2'h0, nv_set_o;
    logic stored_set_load_cmd_i = 1'b0, description_file_choice_i = 1'b0, trailer_mode_on_i = 1'b0;
    logic frame_number_en_i = 1'b0, test_pattern_en_i = 1'b0, frame_start_i = 1'b0, frame_end_i = 1'b0;
    logic pix_valid_i = 1'b0, load_busy_o, load_done_o, load_reject_o, description_store_o;
    logic features_ready_o, colour_adjust_avail_o, sequencer_avail_o, pix_valid_o, trailer_valid_o;
    logic [CSL_PIX_W-1:0] pix_i = 8'h00, pix_o;
    logic [CSL_IDX_W-1:0] nv_index_o;
    logic [CSL_PARAM_W-1:0] nv_rdata_i;
    logic [CSL_PARAM_W*8-1:0] active_params_o;
    logic [CSL_STAMP_W-1:0] trailer_data_o;
    int num_errors = 0, check_count = 0, cycles = 0, frames = 0, tb, tf;
    always #25 sys_clk_i = ~sys_clk_i;
    csl_config_set_loader #(.PARAM_N(8), .BASIC_PROC_CYC(5), .FULL_PROC_CYC(10)) i_dut (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .stored_set_choice_i(stored_set_choice_i),
        .stored_set_load_cmd_i(stored_set_load_cmd_i),
        .startup_set_choice_i(startup_set_choice_i),
        .description_file_choice_i(description_file_choice_i),
        .acquiring_i(acquiring_i),
        .nv_read_done_i(nv_read_done_i),
        .nv_rdata_i(nv_rdata_i),
        .trailer_mode_on_i(trailer_mode_on_i),
        .frame_number_en_i(frame_number_en_i),
        .test_pattern_en_i(test_pattern_en_i),
        .frame_start_i(frame_start_i),
        .frame_end_i(frame_end_i),
        .pix_valid_i(pix_valid_i),
        .pix_i(pix_i),
        .nv_read_o(nv_read_o),
        .nv_set_o(nv_set_o),
        .nv_index_o(nv_index_o),
        .active_params_o(active_params_o),
        .load_busy_o(load_busy_o),
        .load_done_o(load_done_o),
        .load_reject_o(load_reject_o),
        .description_store_o(description_store_o),
        .features_ready_o(features_ready_o),
        .colour_adjust_avail_o(colour_adjust_avail_o),
        .sequencer_avail_o(sequencer_avail_o),
        .pix_valid_o(pix_valid_o),
        .pix_o(pix_o),
        .trailer_valid_o(trailer_valid_o),
        .trailer_data_o(trailer_data_o)
    );
    csl_nv_model i_nv (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .slow_i(slow), .nv_read_i(nv_read_o),
        .nv_set_i(nv_set_o), .nv_index_i(nv_index_o), .nv_read_done_o(nv_read_done_i), .nv_rdata_o(nv_rdata_i));
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask : tick
    function automatic logic [127:0] params_for(input logic [1:0] s);
        for (int i = 0; i < 8; i++) params_for[16*i +: 16] = {s, 3'h5, i[2:0], 8'h96};
    endfunction : params_for
    function automatic logic pick(input int w);
        case (w)
            0: return load_done_o;
            1: return load_reject_o;
            default: return trailer_valid_o;
        endcase
    endfunction : pick
    // Pulse inputs are dropped after the first edge; n is -1 when nothing came.
    task automatic wait_for(input int which, input int limit, output int n);
        n = -1;
        for (int k = 0; k < limit && n < 0; k++) begin
            tick();
            stored_set_load_cmd_i = 1'b0;
            frame_start_i = 1'b0;
            frame_end_i = 1'b0;
            if (pick(which) === 1'b1) n = k;
        end
    endtask : wait_for
    task automatic do_reset(input logic [1:0] s, input logic desc, output int t_ready);
        int t_idle;
        resetn_i = 1'b0;
        startup_set_choice_i = s;
        description_file_choice_i = desc;
        frames = 0;
        repeat (16) tick();
        check(load_busy_o, 1'b1);
        resetn_i = 1'b1;
        t_ready = -1;
        t_idle = -1;
        for (int k = 0; k < 100; k++) begin
            tick();
            if (t_idle < 0 && k > 1 && load_busy_o === 1'b0) t_idle = k;
            if (t_ready < 0 && features_ready_o === 1'b1) t_ready = k;
        end
        check(t_idle >= 0 && t_ready >= 0, 1'b1);
        check(active_params_o, params_for(s));
        check(description_store_o, desc);
        check({colour_adjust_avail_o, sequencer_avail_o}, {desc, desc});
    endtask : do_reset
    task automatic host_load(input logic [1:0] s);
        int n;
        slow = s[0];
        stored_set_choice_i = s;
        tick();
        stored_set_load_cmd_i = 1'b1;
        wait_for(0, 100, n);
        check(n >= 0, 1'b1);
        check(active_params_o, params_for(s));
    endtask : host_load
    task automatic reject_test();
        int n;
        acquiring_i = 1'b1;
        stored_set_choice_i = 2'h1;
        tick();
        stored_set_load_cmd_i = 1'b1;
        wait_for(1, 3, n);
        check(n >= 0, 1'b1);
        repeat (20) tick();
        check(active_params_o, params_for(2'h3));
        acquiring_i = 1'b0;
    endtask : reject_test
    task automatic pattern_test();
        test_pattern_en_i = 1'b1;
        frame_start_i = 1'b1;
        frames++;
        tick();
        frame_start_i = 1'b0;
        for (int k = 0; k < 4; k++) begin
            pix_valid_i = 1'b1;
            pix_i = 8'hE0 + 8'(k);
            tick();
            check({pix_valid_o, pix_o}, {1'b1, 8'(k)});
        end
        test_pattern_en_i = 1'b0;
        pix_i = 8'h3C;
        tick();
        check({pix_valid_o, pix_o}, {1'b1, 8'h3C});
        pix_valid_i = 1'b0;
    endtask : pattern_test
    task automatic trailer_test();
        int n;
        trailer_mode_on_i = 1'b1;
        tick();
        frame_number_en_i = 1'b1;
        for (int f = 0; f < 3; f++) begin
            frame_start_i = 1'b1;
            tick();
            frame_start_i = 1'b0;
            trailer_mode_on_i = (f < 2);
            frame_end_i = 1'b1;
            wait_for(2, 4, n);
            check(n >= 0, f < 2);
            if (f < 2) check(trailer_data_o, 32'(frames));
            frames++;
        end
    endtask : trailer_test
    initial begin
        slow = 1'b0;
        do_reset(2'h2, CSL_DESC_BASIC, tb);
        do_reset(2'h3, CSL_DESC_FULL, tf);
        check(tb >= 5 && tf >= 10 && tb < tf, 1'b1);
        do_reset(2'h0, CSL_DESC_BASIC, tb);
        for (int s = 0; s < 4; s++) host_load(2'(s));
        reject_test();
        pattern_test();
        trailer_test();
        report_and_stop();
    end
endmodule : csl_config_set_loader_bench
`default_nettype wire
